/* rtl/rtpwm_pkg.sv */
// Package with register map, field positions, reset values and bus carriers of the reload timer.
package rtpwm_pkg;
  localparam int unsigned CNT_W        = 12;
  localparam int unsigned NUM_CH       = 4;
  localparam logic [11:0] CNT_TOP      = 12'hFFF;
  localparam logic [11:0] CNT_RST      = 12'h000;
  localparam logic [11:0] RELOAD_RST   = 12'h000;
  localparam logic [11:0] DUTY_RST     = 12'h000;
  localparam logic [3:0]  OE_RST       = 4'h0;
  localparam logic [3:0]  POL_RST      = 4'h0;
  localparam logic        SHADOW_RST   = 1'b1;
  localparam int unsigned SLOW_DIV     = 32;
  localparam logic [4:0]  SLOW_LAST    = 5'(SLOW_DIV - 1);

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_CTRL_STATUS = 6'h0D;
  localparam logic [5:0] IDX_CNT_HI      = 6'h0E;
  localparam logic [5:0] IDX_CNT_LO      = 6'h0F;
  localparam logic [5:0] IDX_RELOAD_HI   = 6'h10;
  localparam logic [5:0] IDX_RELOAD_LO   = 6'h11;
  localparam logic [5:0] IDX_OUT_ENABLE  = 6'h12;
  localparam logic [5:0] IDX_CHAN_CSR0   = 6'h13;
  localparam logic [5:0] IDX_DUTY0_HI    = 6'h17;
  localparam logic [5:0] IDX_CAPTURE_HI  = 6'h1F;
  localparam logic [5:0] IDX_CAPTURE_LO  = 6'h20;
  localparam logic [5:0] IDX_SHADOW_CTRL = 6'h21;
  localparam logic [5:0] IDX_SHUTDOWN    = 6'h22;

  // Control status fields.
  localparam int unsigned CS_CAP_FLAG = 6;
  localparam int unsigned CS_CAP_IE   = 5;
  localparam int unsigned CS_CLK_HI   = 4;
  localparam int unsigned CS_CLK_LO   = 3;
  localparam int unsigned CS_OVF_FLAG = 2;
  localparam int unsigned CS_OVF_IE   = 1;
  localparam int unsigned CS_CMP_IE   = 0;
  // Channel control status fields.
  localparam int unsigned CH_POL      = 1;
  localparam int unsigned CH_CMP_FLAG = 0;
  // Shutdown control fields.
  localparam int unsigned SD_ACTIVE   = 5;
  localparam int unsigned SD_PIN_EN   = 4;

  localparam logic [1:0] CLK_OFF  = 2'b00;
  localparam logic [1:0] CLK_LOW  = 2'b01;
  localparam logic [1:0] CLK_CPU  = 2'b10;
  localparam logic [1:0] CLK_FAST = 2'b11;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } rtpwm_wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } rtpwm_wb_rsp_s;
endpackage : rtpwm_pkg

/* rtl/rtpwm_timer.sv */
// Reload timer with four modulated outputs, shutdown, input capture and a Wishbone register slave.
// What this block does
// - Shared period is clock over 4096 minus reload.
// - Counter counts up from zero after reset.
// - Overflow with shadow enable set loads duty shadows; overflow drives outputs high.
// - Counter equal duty drives channel output low.
// - Polarity inverts; with shadow enable, at overflow.
// - Duty match sets compare flag, maybe interrupt.
// - Compare works only for nonzero duty.
// - Shutdown pin acts only when enabled.
// - Low enabled pin sets shutdown active.
// - Software setting shutdown active also shuts down.
// - Shutdown drives pattern onto pins after inverter.
// - Shutdown holds counter, reload, duties, enables reset.
// - Clearing shutdown returns pins to port registers.
// - Capture edge latches counter, sets flag, interrupt.
// - Capture read clears flag; no recapture while set.
// - Slow mode divides by 32; wait no effect.
// - Halt stops timer; active-halt exception wakes.
// - Compare and capture share request; overflow separate.
// - Two-bit select picks counter clock source.
// - Passing FFFh reloads, sets overflow flag.
// - Shadow enable set by reset, cleared after transfer.
// - Output enable zero frees pin for port use.
module rtpwm_timer (
  input  wire logic                    core_clk_in,         // System clock, 200 MHz.
  input  wire logic                    rst_n_in,            // Synchronous reset, active low.
  input  wire rtpwm_pkg::rtpwm_wb_req_s wb_req_in,          // Wishbone request.
  output rtpwm_pkg::rtpwm_wb_rsp_s     wb_rsp_out,          // Wishbone answer.
  input  wire logic                    low_tick_in,         // Low-speed timebase tick.
  input  wire logic                    fast_tick_in,        // Fast source tick.
  input  wire logic                    slow_mode_in,        // Slow power mode.
  input  wire logic                    halt_in,             // Halt power mode.
  input  wire logic                    active_halt_in,      // Active-halt power mode.
  input  wire logic                    shutdown_n_in,       // Shutdown pin, active low.
  input  wire logic                    capture_input_in,    // Capture pin.
  output logic [3:0]                   modulated_output_n_out, // Modulated outputs.
  output logic [3:0]                   channel_drive_enable_out, // Pin owned by timer.
  output logic                         cmp_cap_irq_out,     // Compare or capture request.
  output logic                         ovf_irq_out,         // Overflow request.
  output logic                         wake_out             // Wake from active-halt.
);
  import rtpwm_pkg::*;

  // Twelve-bit registers are split into a high nibble and a low byte.
  function automatic logic [7:0] hi_byte(input logic [11:0] v);
    hi_byte = {4'h0, v[11:8]};
  endfunction

  function automatic logic [7:0] lo_byte(input logic [11:0] v);
    lo_byte = v[7:0];
  endfunction

  logic [11:0] cnt_r;
  logic [11:0] reload_r;
  logic [11:0] duty_r     [NUM_CH];
  logic [11:0] duty_act_r [NUM_CH];
  logic [3:0]  pol_r;
  logic [3:0]  pol_act_r;
  logic [3:0]  oe_r;
  logic [3:0]  cmp_flag_r;
  logic [3:0]  wave_r;
  logic        shadow_en_r;
  logic        cap_flag_r;
  logic        cap_ie_r;
  logic [1:0]  clk_sel_r;
  logic        ovf_flag_r;
  logic        ovf_ie_r;
  logic        cmp_ie_r;
  logic        sd_active_r;
  logic        sd_pin_en_r;
  logic [3:0]  sd_pattern_r;
  logic [11:0] cap_r;
  logic        cap_prev_r;
  logic [4:0]  slow_cnt_r;
  logic        ack_r;
  logic [31:0] rdat_r;
  logic [3:0]  mod_out_r;
  logic [3:0]  drive_r;
  logic        cmp_cap_irq_r;
  logic        ovf_irq_r;
  logic        wake_r;

  // Bus decode.
  wire         access    = wb_req_in.cyc & wb_req_in.stb & ~ack_r;
  wire [5:0]   idx       = wb_req_in.adr[7:2];
  wire         wr        = access & wb_req_in.we & wb_req_in.sel[0];
  wire         rd        = access & ~wb_req_in.we;
  wire [7:0]   wd        = wb_req_in.dat[7:0];
  wire         wr_cs     = wr & (idx == IDX_CTRL_STATUS);
  wire         wr_rl_hi  = wr & (idx == IDX_RELOAD_HI);
  wire         wr_rl_lo  = wr & (idx == IDX_RELOAD_LO);
  wire         wr_oe     = wr & (idx == IDX_OUT_ENABLE);
  wire         wr_shadow = wr & (idx == IDX_SHADOW_CTRL);
  wire         wr_sd     = wr & (idx == IDX_SHUTDOWN);
  wire         rd_cs     = rd & (idx == IDX_CTRL_STATUS);
  wire         rd_cap    = rd & ((idx == IDX_CAPTURE_HI) | (idx == IDX_CAPTURE_LO));
  wire [5:0]   ch_off    = idx - IDX_CHAN_CSR0;
  wire [5:0]   duty_off  = idx - IDX_DUTY0_HI;
  wire         in_chan   = (idx >= IDX_CHAN_CSR0) & (idx < IDX_DUTY0_HI);
  wire         in_duty   = (idx >= IDX_DUTY0_HI) & (idx < IDX_CAPTURE_HI);
  wire [1:0]   ch_sel    = ch_off[1:0];
  wire [1:0]   duty_sel  = duty_off[2:1];
  wire         duty_lo   = duty_off[0];

  // Per-channel strobes of the channel status and duty windows.
  logic [3:0]  wr_chan;
  logic [3:0]  rd_chan;
  logic [3:0]  wr_duty;
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      wr_chan[c] = wr & in_chan & (ch_sel == 2'(c));
      rd_chan[c] = rd & in_chan & (ch_sel == 2'(c));
      wr_duty[c] = wr & in_duty & (duty_sel == 2'(c));
    end
  end

  // Counter clock: source select, slow-mode division and halt gating.
  wire         src_tick  = (clk_sel_r == CLK_LOW)  ? low_tick_in  :
                           (clk_sel_r == CLK_CPU)  ? 1'b1         :
                           (clk_sel_r == CLK_FAST) ? fast_tick_in : 1'b0;
  // Active-halt keeps only the low-speed timebase with overflow requests running.
  wire         ah_runs   = (clk_sel_r == CLK_LOW) & ovf_ie_r;
  wire         stopped   = halt_in | (active_halt_in & ~ah_runs);
  wire         slow_ok   = ~slow_mode_in | (slow_cnt_r == SLOW_LAST);
  wire         tick      = src_tick & slow_ok & ~stopped & ~sd_active_r;
  wire         at_top    = (cnt_r == CNT_TOP);
  wire         ovf_ev    = tick & at_top;
  wire [11:0]  cnt_nxt   = at_top ? reload_r : cnt_r + 12'h001;
  wire         cmp_avail = (clk_sel_r != CLK_LOW);
  // Shadows load only at an overflow while the shadow enable is set.
  wire         shadow_ld = ovf_ev & shadow_en_r;

  // Duty shadows as seen in the cycle of an overflow.
  logic [11:0] duty_use [NUM_CH];
  logic [3:0]  match;
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      duty_use[c] = shadow_ld ? duty_r[c] : duty_act_r[c];
      // The match looks one count ahead, so the wave falls as the counter takes the duty value.
      match[c]    = tick & cmp_avail & (duty_use[c] != DUTY_RST) & (cnt_nxt == duty_use[c]);
    end
  end

  wire         sd_pin    = sd_pin_en_r & ~shutdown_n_in;
  // A low enabled pin keeps the shutdown active against a software clear.
  wire         sd_nxt    = sd_pin | (wr_sd ? wd[SD_ACTIVE] : sd_active_r);
  // The pin is taken as synchronous; one stored sample shows edges of either direction.
  wire         cap_edge  = capture_input_in ^ cap_prev_r;
  wire         cap_take  = cap_edge & ~cap_flag_r;
  // Without the shadow enable a new polarity acts at once.
  wire [3:0]   pol_use   = shadow_ld ? pol_r :
                           (shadow_en_r ? pol_act_r : pol_r);

  // Unmapped indices and reserved bits read as zero.
  logic [7:0]  rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (idx == IDX_CTRL_STATUS) begin
      rd_mux[CS_CAP_FLAG]         = cap_flag_r;
      rd_mux[CS_CAP_IE]           = cap_ie_r;
      rd_mux[CS_CLK_HI:CS_CLK_LO] = clk_sel_r;
      rd_mux[CS_OVF_FLAG]         = ovf_flag_r;
      rd_mux[CS_OVF_IE]           = ovf_ie_r;
      rd_mux[CS_CMP_IE]           = cmp_ie_r;
    end else if (idx == IDX_CNT_HI) begin
      rd_mux = hi_byte(cnt_r);
    end else if (idx == IDX_CNT_LO) begin
      rd_mux = lo_byte(cnt_r);
    end else if (idx == IDX_RELOAD_HI) begin
      rd_mux = hi_byte(reload_r);
    end else if (idx == IDX_RELOAD_LO) begin
      rd_mux = lo_byte(reload_r);
    end else if (idx == IDX_OUT_ENABLE) begin
      for (int c = 0; c < NUM_CH; c++) begin
        rd_mux[2 * c] = oe_r[c];
      end
    end else if (in_chan) begin
      rd_mux[CH_POL]      = pol_r[ch_sel];
      rd_mux[CH_CMP_FLAG] = cmp_flag_r[ch_sel];
    end else if (in_duty) begin
      rd_mux = duty_lo ? lo_byte(duty_r[duty_sel]) : hi_byte(duty_r[duty_sel]);
    end else if (idx == IDX_CAPTURE_HI) begin
      rd_mux = hi_byte(cap_r);
    end else if (idx == IDX_CAPTURE_LO) begin
      rd_mux = lo_byte(cap_r);
    end else if (idx == IDX_SHADOW_CTRL) begin
      rd_mux = {7'h00, shadow_en_r};
    end else if (idx == IDX_SHUTDOWN) begin
      rd_mux[SD_ACTIVE] = sd_active_r;
      rd_mux[SD_PIN_EN] = sd_pin_en_r;
      rd_mux[3:0]       = sd_pattern_r;
    end
  end

  // Bus slave: one-cycle answer, ack drops the cycle after.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r  <= access;
      rdat_r <= access ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  // Counter and reload.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cnt_r      <= CNT_RST;
      reload_r   <= RELOAD_RST;
      slow_cnt_r <= 5'h00;
    end else begin
      slow_cnt_r <= slow_mode_in ? slow_cnt_r + 5'h01 : 5'h00;
      if (sd_active_r) begin
        cnt_r    <= CNT_RST;
        reload_r <= RELOAD_RST;
      end else begin
        if (tick) begin
          cnt_r <= cnt_nxt;
        end
        if (wr_rl_hi) begin
          reload_r[11:8] <= wd[3:0];
        end
        if (wr_rl_lo) begin
          reload_r[7:0] <= wd;
        end
      end
    end
  end

  // Duty values, shadows, polarity and modulation.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      for (int c = 0; c < NUM_CH; c++) begin
        duty_r[c]     <= DUTY_RST;
        duty_act_r[c] <= DUTY_RST;
      end
      pol_r       <= POL_RST;
      pol_act_r   <= POL_RST;
      oe_r        <= OE_RST;
      wave_r      <= 4'h0;
      shadow_en_r <= SHADOW_RST;
    end else begin
      pol_act_r <= pol_use;
      for (int c = 0; c < NUM_CH; c++) begin
        if (wr_chan[c]) begin
          pol_r[c] <= wd[CH_POL];
        end
      end
      if (sd_active_r) begin
        for (int c = 0; c < NUM_CH; c++) begin
          duty_r[c]     <= DUTY_RST;
          duty_act_r[c] <= DUTY_RST;
        end
        oe_r   <= OE_RST;
        wave_r <= 4'h0;
      end else begin
        for (int c = 0; c < NUM_CH; c++) begin
          duty_act_r[c] <= duty_use[c];
          if (wr_duty[c]) begin
            if (duty_lo) begin
              duty_r[c][7:0] <= wd;
            end else begin
              duty_r[c][11:8] <= wd[3:0];
            end
          end
          // The low-speed timebase gives no waveform, so the wave stays low.
          if (match[c] | ~cmp_avail) begin
            wave_r[c] <= 1'b0;
          end else if (ovf_ev) begin
            wave_r[c] <= 1'b1;
          end
        end
        if (wr_oe) begin
          oe_r <= {wd[6], wd[4], wd[2], wd[0]};
        end
      end
      // A completed transfer clears the enable even against a same-cycle write.
      if (shadow_ld) begin
        shadow_en_r <= 1'b0;
      end else if (wr_shadow) begin
        shadow_en_r <= wd[0];
      end
    end
  end

  // Flags, control bits, shutdown and capture.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cmp_flag_r   <= 4'h0;
      cap_flag_r   <= 1'b0;
      cap_ie_r     <= 1'b0;
      clk_sel_r    <= CLK_OFF;
      ovf_flag_r   <= 1'b0;
      ovf_ie_r     <= 1'b0;
      cmp_ie_r     <= 1'b0;
      sd_active_r  <= 1'b0;
      sd_pin_en_r  <= 1'b0;
      sd_pattern_r <= 4'h0;
      cap_r        <= 12'h000;
      cap_prev_r   <= 1'b0;
    end else begin
      // Compare, overflow and shutdown-pin sets win over a clear in the same cycle; a capture edge during the clearing read is lost.
      cap_prev_r <= capture_input_in;
      for (int c = 0; c < NUM_CH; c++) begin
        if (match[c]) begin
          cmp_flag_r[c] <= 1'b1;
        end else if (rd_chan[c]) begin
          cmp_flag_r[c] <= 1'b0;
        end
      end
      if (ovf_ev) begin
        ovf_flag_r <= 1'b1;
      end else if (rd_cs) begin
        ovf_flag_r <= 1'b0;
      end
      // The capture takes the counter as it stood before the edge was seen.
      if (cap_take) begin
        cap_r      <= cnt_r;
        cap_flag_r <= 1'b1;
      end else if (rd_cap & cap_flag_r) begin
        cap_flag_r <= 1'b0;
      end
      if (wr_cs) begin
        cap_ie_r  <= wd[CS_CAP_IE];
        clk_sel_r <= wd[CS_CLK_HI:CS_CLK_LO];
        ovf_ie_r  <= wd[CS_OVF_IE];
        cmp_ie_r  <= wd[CS_CMP_IE];
      end
      sd_active_r <= sd_nxt;
      if (wr_sd) begin
        sd_pin_en_r  <= wd[SD_PIN_EN];
        sd_pattern_r <= wd[3:0];
      end
    end
  end

  // Shutdown takes every pin and forces the pattern behind the polarity stage.
  wire [3:0]   pin_nxt   = sd_active_r ? sd_pattern_r : (wave_r ^ pol_act_r);
  wire [3:0]   drive_nxt = sd_active_r ? 4'hF : oe_r;
  // Compare and capture share one request line; overflow has its own.
  wire         cc_req    = (cmp_ie_r & (|cmp_flag_r)) | (cap_ie_r & cap_flag_r);
  wire         ovf_req   = ovf_ie_r & ovf_flag_r;
  wire         wake_req  = active_halt_in & ah_runs & ovf_flag_r;

  // Registered pin and request outputs.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      mod_out_r     <= 4'h0;
      drive_r       <= 4'h0;
      cmp_cap_irq_r <= 1'b0;
      ovf_irq_r     <= 1'b0;
      wake_r        <= 1'b0;
    end else begin
      mod_out_r     <= pin_nxt;
      drive_r       <= drive_nxt;
      cmp_cap_irq_r <= cc_req;
      ovf_irq_r     <= ovf_req;
      wake_r        <= wake_req;
    end
  end

  assign wb_rsp_out.ack           = ack_r;
  assign wb_rsp_out.dat           = rdat_r;
  assign modulated_output_n_out   = mod_out_r;
  assign channel_drive_enable_out = drive_r;
  assign cmp_cap_irq_out          = cmp_cap_irq_r;
  assign ovf_irq_out              = ovf_irq_r;
  assign wake_out                 = wake_r;
endmodule // rtpwm_timer

/* test/rtpwm_timer_assertions.sv */
// Checker of bus timing, interrupt, wake and shutdown relations at the timer ports.
module rtpwm_timer_assertions (
  input wire logic                     core_clk_in,              // Clock.
  input wire logic                     rst_n_in,                 // Reset, low.
  input wire rtpwm_pkg::rtpwm_wb_req_s wb_req_in,                // Bus request.
  input wire rtpwm_pkg::rtpwm_wb_rsp_s wb_rsp_out,               // Bus answer.
  input wire logic                     active_halt_in,           // Active-halt mode.
  input wire logic [3:0]               modulated_output_n_out,   // Pins.
  input wire logic [3:0]               channel_drive_enable_out, // Pin ownership.
  input wire logic                     cmp_cap_irq_out,          // Compare or capture request.
  input wire logic                     ovf_irq_out,              // Overflow request.
  input wire logic                     wake_out                  // Wake request.
);
  timeunit 1ns;
  timeprecision 1ps;
  import rtpwm_pkg::*;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire take = wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack;
  wire ctrl_ack = wb_rsp_out.ack && wb_req_in.adr[7:2] == IDX_CTRL_STATUS;
  sequence sd_write_s;
    take && wb_req_in.we && wb_req_in.sel[0] && wb_req_in.adr[7:2] == IDX_SHUTDOWN && wb_req_in.dat[SD_ACTIVE];
  endsequence
  sequence pattern_out_s;
    channel_drive_enable_out == 4'hF && modulated_output_n_out == $past(wb_req_in.dat[3:0], 2);
  endsequence
  ack_one_cycle_a: assert property (wb_rsp_out.ack |=> !wb_rsp_out.ack)
    else $error("ack held too long");
  ack_answer_a: assert property (take |=> wb_rsp_out.ack)
    else $error("request not answered");
  ack_idle_a: assert property (!(wb_req_in.cyc && wb_req_in.stb) |=> !wb_rsp_out.ack)
    else $error("ack without request");
  rdata_upper_a: assert property (wb_rsp_out.ack |-> wb_rsp_out.dat[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  reset_quiet_a: assert property ($past(!rst_n_in) |-> wb_rsp_out == '0 && modulated_output_n_out == 4'h0
    && channel_drive_enable_out == 4'h0 && !cmp_cap_irq_out && !ovf_irq_out && !wake_out)
    else $error("outputs active after reset");
  ovf_irq_fall_a: assert property ($fell(ovf_irq_out) |-> ctrl_ack || $past(ctrl_ack))
    else $error("overflow request fell without access");
  cmp_irq_fall_a: assert property ($fell(cmp_cap_irq_out) |-> wb_rsp_out.ack || $past(wb_rsp_out.ack))
    else $error("compare request fell without access");
  wake_tie_a: assert property (wake_out |-> ovf_irq_out && $past(active_halt_in))
    else $error("wake without overflow request");
  sw_shutdown_a: assert property (sd_write_s |-> ##2 pattern_out_s)
    else $error("shutdown pattern not on pins");
endmodule // rtpwm_timer_assertions

bind rtpwm_timer rtpwm_timer_assertions u_chk (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
  .wb_req_in(wb_req_in), .wb_rsp_out(wb_rsp_out), .active_halt_in(active_halt_in),
  .modulated_output_n_out(modulated_output_n_out), .channel_drive_enable_out(channel_drive_enable_out),
  .cmp_cap_irq_out(cmp_cap_irq_out), .ovf_irq_out(ovf_irq_out), .wake_out(wake_out));

/* test/rtpwm_far_side.sv */
// Converter stage and capture source facing the timer pins.
module rtpwm_far_side (
  input  wire logic        core_clk_in,    // Clock.
  input  wire logic        trip_in,        // Raise a fault.
  input  wire logic        edge_req_in,    // Ask for one capture edge.
  input  wire logic [3:0]  edge_lag_in,    // Delay of that edge.
  input  wire logic        wave_in,        // Channel 0 pin.
  output logic             shutdown_n_out, // Fault line, pulled up.
  output logic             capture_out,    // Capture signal.
  output logic [15:0]      period_out      // Cycles between rising edges.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        cap_r  = 1'b0;
  logic        pend_r = 1'b0;
  logic        wave_r = 1'b0;
  logic [3:0]  lag_r  = 4'h0;
  logic [15:0] cnt_r  = 16'h0000;
  logic [15:0] per_r  = 16'h0000;
  assign shutdown_n_out = !trip_in;
  assign capture_out = cap_r;
  assign period_out = per_r;
  always @(posedge core_clk_in) begin
    wave_r <= wave_in;
    cnt_r <= (wave_in && !wave_r) ? 16'h0001 : cnt_r + 16'h0001;
    if (wave_in && !wave_r) per_r <= cnt_r;
    if (edge_req_in) begin
      pend_r <= 1'b1;
      lag_r <= edge_lag_in;
    end else if (pend_r && lag_r != 4'h0) begin
      lag_r <= lag_r - 4'h1;
    end else if (pend_r) begin
      pend_r <= 1'b0;
      cap_r <= !cap_r;
    end
  end
endmodule // rtpwm_far_side

/* test/test_rtpwm_timer.sv */
// Self-checking bench of the reload timer with its far-side model.
module test_rtpwm_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import rtpwm_pkg::*;
  `define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; $display("BAD %0t %h vs %h", $time, g, e); end end
  typedef struct packed {
    logic       we;
    logic [5:0] idx;
    logic [7:0] dat;
  } rtpwm_row_s;
  // Reads carry the expected value, writes the value written.
  localparam rtpwm_row_s ROWS [16] = '{
    '{1'b0, IDX_CTRL_STATUS, 8'h00}, '{1'b0, IDX_CNT_HI, 8'h00}, '{1'b0, IDX_CNT_LO, 8'h00},
    '{1'b0, IDX_RELOAD_LO, 8'h00}, '{1'b0, IDX_OUT_ENABLE, 8'h00}, '{1'b0, IDX_CHAN_CSR0, 8'h00},
    '{1'b0, IDX_DUTY0_HI, 8'h00}, '{1'b0, IDX_CAPTURE_LO, 8'h00}, '{1'b0, IDX_SHADOW_CTRL, 8'h01},
    '{1'b0, IDX_SHUTDOWN, 8'h00}, '{1'b1, IDX_RELOAD_HI, 8'hFF}, '{1'b0, IDX_RELOAD_HI, 8'h0F},
    '{1'b1, IDX_OUT_ENABLE, 8'hFF}, '{1'b0, IDX_OUT_ENABLE, 8'h55}, '{1'b1, 6'h3F, 8'hAA}, '{1'b0, 6'h3F, 8'h00}};
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  rtpwm_wb_req_s req = '0;
  rtpwm_wb_rsp_s rsp;
  logic          low_tick = 1'b0;
  logic          fast_tick = 1'b0;
  logic          slow = 1'b0;
  logic          halt = 1'b0;
  logic          ahalt = 1'b0;
  logic          trip = 1'b0;
  logic          ereq = 1'b0;
  logic [3:0]    elag = 4'h0;
  logic          shut_n;
  logic          cap_in;
  logic [3:0]    pwm;
  logic [3:0]    drv;
  logic          cc_irq;
  logic          ov_irq;
  logic          wake;
  logic [15:0]   period;
  logic [3:0]    tick_ctr = 4'h0;
  logic [7:0]    r;
  logic [7:0]    c1;
  int            fail_count = 0;
  int            cmp_count = 0;
  int            n;
  rtpwm_timer DUT (.core_clk_in(clk), .rst_n_in(rst_n), .wb_req_in(req), .wb_rsp_out(rsp), .low_tick_in(low_tick),
    .fast_tick_in(fast_tick), .slow_mode_in(slow), .halt_in(halt), .active_halt_in(ahalt),
    .shutdown_n_in(shut_n), .capture_input_in(cap_in), .modulated_output_n_out(pwm),
    .channel_drive_enable_out(drv), .cmp_cap_irq_out(cc_irq), .ovf_irq_out(ov_irq), .wake_out(wake));
  rtpwm_far_side u_far (.core_clk_in(clk), .trip_in(trip), .edge_req_in(ereq), .edge_lag_in(elag),
    .wave_in(pwm[0]), .shutdown_n_out(shut_n), .capture_out(cap_in), .period_out(period));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    tick_ctr <= tick_ctr + 4'h1;
    low_tick <= tick_ctr[0];
    fast_tick <= tick_ctr[1:0] == 2'h0;
  end
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d, output logic [7:0] q);
    int k;
    k = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {i, 2'h0}, sel: 4'h1, dat: {24'h00_0000, d}};
    @(posedge clk);
    while (rsp.ack !== 1'b1 && k < 16) begin
      @(posedge clk);
      k++;
    end
    if (k == 16) begin
      fail_count++;
      end_sim();
    end
    q = rsp.dat[7:0];
    req <= '0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    bus(1'b1, i, d, r);
  endtask
  task automatic rd(input logic [5:0] i);
    bus(1'b0, i, 8'h00, r);
  endtask
  task automatic high_time(output int h);
    h = 0;
    repeat (256) begin
      @(posedge clk);
      if (pwm[0] === 1'b1) h++;
    end
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end
  initial begin
    @(posedge clk);
    do_reset();
    foreach (ROWS[j]) begin
      bus(ROWS[j].we, ROWS[j].idx, ROWS[j].dat, r);
      if (!ROWS[j].we) `CHK(r, ROWS[j].dat)
    end
    do_reset();
    wr(IDX_RELOAD_HI, 8'h0F);
    wr(IDX_DUTY0_HI, 8'h0F);
    wr(IDX_DUTY0_HI + 6'h01, 8'hC0);
    wr(IDX_OUT_ENABLE, 8'h05);
    wr(IDX_CTRL_STATUS, 8'h13);
    repeat (4700) @(posedge clk);
    `CHK(period, 16'h0100)
    high_time(n);
    `CHK(n, 192)
    `CHK({ov_irq, cc_irq, drv}, 6'h33)
    rd(IDX_CTRL_STATUS);
    `CHK(r, 8'h17)
    rd(IDX_CHAN_CSR0 + 6'h01);
    `CHK(r, 8'h00)
    rd(IDX_SHADOW_CTRL);
    `CHK(r, 8'h00)
    wr(IDX_SHADOW_CTRL, 8'h01);
    wr(IDX_CHAN_CSR0, 8'h02);
    repeat (300) @(posedge clk);
    high_time(n);
    `CHK(n, 64)
    trip <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(drv, 4'h3)
    wr(IDX_SHUTDOWN, 8'h1A);
    repeat (3) @(posedge clk);
    `CHK({drv, pwm}, 8'hFA)
    trip <= 1'b0;
    rd(IDX_SHUTDOWN);
    `CHK(r, 8'h3A)
    rd(IDX_CNT_LO);
    `CHK(r, 8'h00)
    rd(IDX_OUT_ENABLE);
    `CHK(r, 8'h00)
    rd(IDX_DUTY0_HI);
    `CHK(r, 8'h00)
    wr(IDX_SHUTDOWN, 8'h10);
    repeat (3) @(posedge clk);
    `CHK(drv, 4'h0)
    wr(IDX_SHUTDOWN, 8'h25);
    repeat (3) @(posedge clk);
    `CHK({drv, pwm}, 8'hF5)
    wr(IDX_SHUTDOWN, 8'h00);
    do_reset();
    wr(IDX_CTRL_STATUS, 8'h30);
    rd(IDX_CNT_LO);
    c1 = r;
    ereq <= 1'b1;
    elag <= 4'h9;
    @(posedge clk);
    ereq <= 1'b0;
    repeat (30) @(posedge clk);
    `CHK(cc_irq, 1'b1)
    // A second edge while the flag is set must not replace the value.
    ereq <= 1'b1;
    elag <= 4'h0;
    @(posedge clk);
    ereq <= 1'b0;
    repeat (4) @(posedge clk);
    rd(IDX_CAPTURE_LO);
    `CHK(8'(r - c1) inside {[8'h08:8'h14]}, 1'b1)
    wr(IDX_CTRL_STATUS, 8'h70);
    rd(IDX_CTRL_STATUS);
    `CHK(r, 8'h30)
    slow <= 1'b1;
    rd(IDX_CNT_LO);
    c1 = r;
    repeat (318) @(posedge clk);
    rd(IDX_CNT_LO);
    `CHK(8'(r - c1) inside {[8'h09:8'h0B]}, 1'b1)
    halt <= 1'b1;
    repeat (2) @(posedge clk);
    rd(IDX_CNT_LO);
    c1 = r;
    repeat (100) @(posedge clk);
    rd(IDX_CNT_LO);
    `CHK(r, c1)
    slow <= 1'b0;
    halt <= 1'b0;
    wr(IDX_CTRL_STATUS, 8'h38);
    rd(IDX_CNT_LO);
    c1 = r;
    repeat (200) @(posedge clk);
    rd(IDX_CNT_LO);
    `CHK(8'(r - c1) inside {[8'h32:8'h33]}, 1'b1)
    do_reset();
    wr(IDX_CTRL_STATUS, 8'h0A);
    ahalt <= 1'b1;
    n = 0;
    while (wake !== 1'b1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    `CHK(wake, 1'b1)
    `CHK(pwm, 4'h0)
    end_sim();
  end
endmodule // test_rtpwm_timer
